// ---- logic/csm_channel.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Words are 7 or 8 bits, shifted MSB first or LSB first.
// - Master serial clock never exceeds half the system clock.
// - Period comes from unit prescaler then per-channel divide counter.
// - Mode bit picks prescaler output A (0) or B (1).
// - Data phase 0 drives at first edge; 1 drives half period early.
// - Clock phase bit is unused; drive and sample edges follow the clock idle level and data phase.
// - Master makes the serial clock and shifts data with it.
// - Interrupt source 0 is transfer end; 1 is buffer empty.
// - Reception flags overrun on lost word; transmission has no error flag.
// - Low 8 data register bits are the transmit and receive buffer.
// - Writing data while buffer full replaces the pending word.
// - Interrupt source may change live, before the last word's last bit.
// - Stop trigger clears channel enabled; trigger reads back zero.
// - Output enable low holds serial data at its software level; the clock pin takes its level only when idle or stopped.
// - In stop low-power state the channel still receives unaided.
// - Start trigger sets channel enabled and enables operation.
module csm_channel
  import csm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  input wire logic low_power_stop,
  output logic serial_clock_pin,
  output logic serial_out_pin,
  output logic channel_irq,
  output logic snooze_rx_done
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  csm_cfg_t cfg;
  logic [7:0] mode_reg;
  logic [7:0] comm_reg;
  logic [6:0] div_reg;
  logic [7:0] prescale_reg;
  logic output_enable_bit;
  logic data_out_level;
  logic clock_out_level;
  logic [7:0] data_buf_reg;
  logic buffer_full_flag;
  logic rx_unread_reg;
  logic overrun_flag;
  logic channel_enabled_flag;
  logic transfer_active_flag;
  csm_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_reg;
  logic [3:0] edge_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic sck_reg;
  logic so_reg;
  logic irq_reg;
  logic snooze_reg;

  logic wr;
  logic rd;
  logic start_trigger_bit;
  logic stop_trigger_bit;
  logic data_wr;
  logic tick_a;
  logic tick_b;
  logic fmck;
  logic half_tick;
  logic start_word;
  logic [3:0] last_edge;
  logic drive_edge;
  logic sample_edge;
  logic finish;
  logic out_bit;
  logic [7:0] shift_next;
  logic [7:0] rx_next;

  assign cfg = {mode_reg[CSM_MODE_IRQ_SRC], mode_reg[CSM_MODE_CK_SEL],
                comm_reg[CSM_COMM_DAP], comm_reg[CSM_COMM_CKP],
                comm_reg[CSM_COMM_LSB], comm_reg[CSM_COMM_LEN8],
                comm_reg[CSM_COMM_TX_EN], comm_reg[CSM_COMM_RX_EN]};

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_clock_pin = sck_reg;
  assign serial_out_pin = so_reg;
  assign channel_irq = irq_reg;
  assign snooze_rx_done = snooze_reg;

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, answer from flops
  // ----------------------------------------------------------------
  assign wr = psel && penable && pready_reg && pwrite;
  assign rd = psel && penable && pready_reg && !pwrite;
  assign start_trigger_bit = wr && (paddr == CSM_OFS_START) && pwdata[0];
  assign stop_trigger_bit = wr && (paddr == CSM_OFS_STOP) && pwdata[0];
  assign data_wr = wr && (paddr == CSM_OFS_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      case (paddr)
        CSM_OFS_MODE: prdata_reg[7:0] <= mode_reg;
        CSM_OFS_COMM: prdata_reg[7:0] <= comm_reg;
        CSM_OFS_DATA: prdata_reg[15:0] <= {div_reg, 1'b0, data_buf_reg};
        CSM_OFS_STATUS: prdata_reg[3:0] <= {channel_enabled_flag, overrun_flag,
                                            transfer_active_flag, buffer_full_flag};
        CSM_OFS_START, CSM_OFS_STOP, CSM_OFS_FLAG_CLR: prdata_reg <= 32'h0000_0000;
        CSM_OFS_OUT_EN: prdata_reg[0] <= output_enable_bit;
        CSM_OFS_OUT_LVL: prdata_reg[8:0] <= {clock_out_level, 7'h00, data_out_level};
        CSM_OFS_PRESCALE: prdata_reg[7:0] <= prescale_reg;
        default: pslverr_reg <= 1'b1;
      endcase
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= CSM_RST_MODE;
      comm_reg <= CSM_RST_COMM;
      div_reg <= CSM_RST_DIV;
      prescale_reg <= CSM_RST_PRESCALE;
      output_enable_bit <= CSM_RST_OUT_EN;
      data_out_level <= CSM_RST_LVL;
      clock_out_level <= CSM_RST_LVL;
    end else if (wr) begin
      case (paddr)
        CSM_OFS_MODE: mode_reg <= pwdata[7:0];
        CSM_OFS_COMM: comm_reg <= pwdata[7:0];
        CSM_OFS_DATA: div_reg <= pwdata[CSM_DATA_DIV_LSB +: 7];
        CSM_OFS_OUT_EN: output_enable_bit <= pwdata[0];
        CSM_OFS_OUT_LVL: begin
          data_out_level <= pwdata[CSM_LVL_DATA];
          clock_out_level <= pwdata[CSM_LVL_CLK];
        end
        CSM_OFS_PRESCALE: prescale_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  csm_prescaler u_ps_a (
    .pclk(pclk),
    .presetn(presetn),
    .sel(prescale_reg[CSM_PS_A_LSB +: 4]),
    .tick(tick_a)
  );

  csm_prescaler u_ps_b (
    .pclk(pclk),
    .presetn(presetn),
    .sel(prescale_reg[CSM_PS_B_LSB +: 4]),
    .tick(tick_b)
  );

  assign fmck = cfg.ck_sel ? tick_b : tick_a;

  // Half period = 2^ps x (div+1) cycles, never below one cycle
  csm_divcnt u_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(state_reg == CSM_ST_IDLE),
    .step(fmck),
    .div(div_reg),
    .half_tick(half_tick)
  );

  // ----------------------------------------------------------------
  // Channel enable and buffer flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enabled_flag <= 1'b0;
    end else if (stop_trigger_bit) begin
      channel_enabled_flag <= 1'b0;
    end else if (start_trigger_bit) begin
      channel_enabled_flag <= 1'b1;
    end
  end

  assign start_word = channel_enabled_flag && !stop_trigger_bit &&
                      (state_reg == CSM_ST_IDLE) && buffer_full_flag;
  assign last_edge = cfg.len8 ? CSM_LAST_EDGE_8 : CSM_LAST_EDGE_7;
  assign finish = (state_reg == CSM_ST_SHIFT) && half_tick && (edge_reg == last_edge);

  // Software write wins over the load that empties the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_full_flag <= 1'b0;
    end else if (data_wr) begin
      buffer_full_flag <= 1'b1;
    end else if (start_word) begin
      buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_buf_reg <= 8'h00;
    end else if (data_wr) begin
      data_buf_reg <= pwdata[7:0];
    end else if (finish && cfg.rx_en) begin
      // Phase 1 ends on a drive edge, so the last bit is already held
      data_buf_reg <= sample_edge ? rx_next : rx_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_unread_reg <= 1'b0;
    end else if (finish && cfg.rx_en) begin
      rx_unread_reg <= 1'b1;
    end else if ((rd || wr) && (paddr == CSM_OFS_DATA)) begin
      rx_unread_reg <= 1'b0;
    end
  end

  // Set wins over the software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag <= 1'b0;
    end else if (finish && cfg.rx_en && rx_unread_reg) begin
      overrun_flag <= 1'b1;
    end else if (wr && (paddr == CSM_OFS_FLAG_CLR) && pwdata[0]) begin
      overrun_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  // Phase 0 drives on even edges; phase 1 drives before the clock
  assign drive_edge = half_tick && (state_reg == CSM_ST_SHIFT) &&
                      (cfg.dap ? (edge_reg[0] && !finish) : !edge_reg[0]);
  assign sample_edge = half_tick && (state_reg == CSM_ST_SHIFT) &&
                       (cfg.dap ? !edge_reg[0] : edge_reg[0]);
  assign out_bit = cfg.lsb ? shift_reg[0] : (cfg.len8 ? shift_reg[7] : shift_reg[6]);
  assign shift_next = cfg.lsb ? {1'b0, shift_reg[7:1]} : {shift_reg[6:0], 1'b0};

  always_comb begin
    rx_next = {rx_reg[6:0], serial_in_pin};
    if (cfg.lsb) begin
      rx_next = cfg.len8 ? {serial_in_pin, rx_reg[7:1]} : {1'b0, serial_in_pin, rx_reg[6:1]};
    end else if (!cfg.len8) begin
      rx_next = {1'b0, rx_reg[5:0], serial_in_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CSM_ST_IDLE;
      transfer_active_flag <= 1'b0;
      edge_reg <= 4'h0;
    end else begin
      case (state_reg)
        CSM_ST_IDLE: begin
          edge_reg <= 4'h0;
          if (start_word) begin
            state_reg <= CSM_ST_SHIFT;
            transfer_active_flag <= 1'b1;
          end
        end
        CSM_ST_SHIFT: begin
          if (stop_trigger_bit || finish) begin
            state_reg <= CSM_ST_IDLE;
            transfer_active_flag <= 1'b0;
          end else if (half_tick) begin
            edge_reg <= edge_reg + 4'h1;
          end
        end
        default: state_reg <= CSM_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
    end else if (start_word && cfg.dap) begin
      // First bit is already on the pin, so the shifter starts one bit on
      shift_reg <= cfg.lsb ? {1'b0, data_buf_reg[7:1]} : {data_buf_reg[6:0], 1'b0};
    end else if (start_word) begin
      shift_reg <= data_buf_reg;
    end else if (drive_edge) begin
      shift_reg <= shift_next;
    end
  end

  // Input taken at each sample edge; rate bounded by operation clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= 8'h00;
    end else if (sample_edge) begin
      rx_reg <= rx_next;
    end
  end

  // Clock toggles from the idle level software chose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_reg <= CSM_RST_LVL;
    end else if (state_reg == CSM_ST_IDLE || !channel_enabled_flag) begin
      sck_reg <= clock_out_level;
    end else if (half_tick) begin
      sck_reg <= ~sck_reg;
    end
  end

  // Phase 1 puts the first bit out when the word is loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so_reg <= CSM_RST_LVL;
    end else if (!output_enable_bit || !cfg.tx_en) begin
      so_reg <= data_out_level;
    end else if (start_word && cfg.dap) begin
      so_reg <= cfg.lsb ? data_buf_reg[0] : (cfg.len8 ? data_buf_reg[7] : data_buf_reg[6]);
    end else if (drive_edge) begin
      so_reg <= out_bit;
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Source bit is read live at each event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (finish && !cfg.irq_src) || (start_word && cfg.irq_src);
    end
  end

  // Word finished without the processor while in low-power stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snooze_reg <= 1'b0;
    end else begin
      snooze_reg <= finish && cfg.rx_en && low_power_stop;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_stop_clears_en: assert property (@(posedge pclk) disable iff (!presetn)
    stop_trigger_bit |=> !channel_enabled_flag && state_reg == CSM_ST_IDLE)
    else $error("stop trigger did not halt the channel");
  chk_start_sets_en: assert property (@(posedge pclk) disable iff (!presetn)
    start_trigger_bit && !stop_trigger_bit |=> channel_enabled_flag)
    else $error("start trigger did not enable the channel");
  chk_sck_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == CSM_ST_SHIFT) && channel_enabled_flag && sck_reg != $past(sck_reg)
    |-> $past(half_tick))
    else $error("serial clock changed without a half period tick");
  chk_end_irq: assert property (@(posedge pclk) disable iff (!presetn)
    finish && !cfg.irq_src |=> irq_reg && !transfer_active_flag)
    else $error("transfer end interrupt missing");
  chk_empty_irq: assert property (@(posedge pclk) disable iff (!presetn)
    start_word && cfg.irq_src && !data_wr |=> irq_reg && !buffer_full_flag ##1 !irq_reg)
    else $error("buffer empty interrupt wrong");
  chk_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    finish && cfg.rx_en && rx_unread_reg |=> overrun_flag)
    else $error("lost word not flagged");
  chk_buf_replace: assert property (@(posedge pclk) disable iff (!presetn)
    data_wr |=> buffer_full_flag && data_buf_reg == $past(pwdata[7:0]))
    else $error("buffered word not replaced");
  chk_oe_level: assert property (@(posedge pclk) disable iff (!presetn)
    !output_enable_bit |=> so_reg == $past(data_out_level))
    else $error("serial output not at software level");
  chk_word_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(transfer_active_flag) && !cfg.len8 && div_reg == 7'h00 &&
    prescale_reg == 8'h00 && !cfg.ck_sel |-> ##14 $fell(transfer_active_flag))
    else $error("seven bit word took wrong time");

  cov_word8: cover property (@(posedge pclk) disable iff (!presetn) finish && cfg.len8);
  cov_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(overrun_flag));
  cov_dap1: cover property (@(posedge pclk) disable iff (!presetn) start_word && cfg.dap);
  cov_urgent_stop: cover property (@(posedge pclk) disable iff (!presetn)
    stop_trigger_bit && transfer_active_flag);

endmodule

// ---- logic/csm_pkg.sv ----
package csm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CSM_OFS_MODE = 12'h000;
  localparam logic [11:0] CSM_OFS_COMM = 12'h004;
  localparam logic [11:0] CSM_OFS_DATA = 12'h008;
  localparam logic [11:0] CSM_OFS_STATUS = 12'h00c;
  localparam logic [11:0] CSM_OFS_START = 12'h010;
  localparam logic [11:0] CSM_OFS_STOP = 12'h014;
  localparam logic [11:0] CSM_OFS_OUT_EN = 12'h018;
  localparam logic [11:0] CSM_OFS_OUT_LVL = 12'h01c;
  localparam logic [11:0] CSM_OFS_PRESCALE = 12'h020;
  localparam logic [11:0] CSM_OFS_FLAG_CLR = 12'h024;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSM_MODE_IRQ_SRC = 0;
  localparam int CSM_MODE_CK_SEL = 1;
  localparam int CSM_COMM_DAP = 0;
  localparam int CSM_COMM_CKP = 1;
  localparam int CSM_COMM_LSB = 2;
  localparam int CSM_COMM_LEN8 = 3;
  localparam int CSM_COMM_TX_EN = 4;
  localparam int CSM_COMM_RX_EN = 5;
  localparam int CSM_DATA_DIV_LSB = 9;
  localparam int CSM_ST_BFF = 0;
  localparam int CSM_ST_TSF = 1;
  localparam int CSM_ST_OVF = 2;
  localparam int CSM_ST_SE = 3;
  localparam int CSM_LVL_DATA = 0;
  localparam int CSM_LVL_CLK = 8;
  localparam int CSM_PS_A_LSB = 0;
  localparam int CSM_PS_B_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CSM_RST_MODE = 8'h00;
  localparam logic [7:0] CSM_RST_COMM = 8'h38;
  localparam logic [6:0] CSM_RST_DIV = 7'h00;
  localparam logic [7:0] CSM_RST_PRESCALE = 8'h00;
  localparam logic CSM_RST_OUT_EN = 1'b0;
  localparam logic CSM_RST_LVL = 1'b1;
  localparam int CSM_PS_WIDTH = 15;
  localparam logic [3:0] CSM_LAST_EDGE_8 = 4'hf;
  localparam logic [3:0] CSM_LAST_EDGE_7 = 4'hd;

  typedef enum logic [0:0] {
    CSM_ST_IDLE,
    CSM_ST_SHIFT
  } csm_state_t;

  typedef struct packed {
    logic irq_src;
    logic ck_sel;
    logic dap;
    logic ckp;
    logic lsb;
    logic len8;
    logic tx_en;
    logic rx_en;
  } csm_cfg_t;

endpackage

// ---- logic/csm_prescaler.sv ----
`timescale 1ns/1ns
module csm_prescaler
  import csm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] sel,
  output logic tick
);

  logic [CSM_PS_WIDTH-1:0] cnt_reg;
  logic [CSM_PS_WIDTH-1:0] mask;

  // Divide by 2^sel; sel of zero gives an enable on every cycle
  assign mask = CSM_PS_WIDTH'((16'h0001 << sel) - 16'h0001);
  assign tick = ((cnt_reg & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

// ---- logic/csm_divcnt.sv ----
`timescale 1ns/1ns
module csm_divcnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic step,
  input wire logic [6:0] div,
  output logic half_tick
);

  logic [6:0] cnt_reg;

  assign half_tick = step && !restart && (cnt_reg == div);

  // Restart keeps the first half period of a word a full count of prescaler steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
    end else if (restart) begin
      cnt_reg <= 7'h00;
    end else if (step) begin
      cnt_reg <= (cnt_reg == div) ? 7'h00 : cnt_reg + 7'h01;
    end
  end

endmodule

// ---- verification/csm_slave_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Far-side serial slave, clock idles high
// ----------------------------------------
module csm_slave_model (
  input wire logic sclk,
  input wire logic sout,
  input wire logic arm,
  input wire logic lsb_first,
  input wire logic len8,
  input wire logic data_phase,
  input wire logic [7:0] tx_word,
  output logic sin,
  output logic [7:0] rx_word
);
  int n = 0;
  initial sin = 1'b1;
  function automatic int pos(input int k);
    return lsb_first ? k : (len8 ? 7 : 6) - k;
  endfunction
  always @(posedge arm) begin
    n = 0;
    rx_word = 8'h00;
    sin = tx_word[pos(0)];
  end
  // Phase 0 samples on rising edges, phase 1 on falling edges
  always @(sclk) begin
    if (n < (len8 ? 8 : 7)) begin
      if (sclk === !data_phase) begin
        rx_word[pos(n)] = sout;
        n++;
        // Released line must not keep the last bit
        if (n == (len8 ? 8 : 7)) begin
          sin = ~sin;
        end
      end else begin
        sin = tx_word[pos(n)];
      end
    end
  end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
module testbench
  import csm_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic low_power_stop = 1'b0, arm = 1'b0, lsb = 1'b0, len8 = 1'b1, dap = 1'b0, err, prev;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sin, sclk, sout, irq, snz;
  logic [7:0] tx_word = 8'h00, rx_word;
  int fail_count = 0, check_count = 0, irq_n = 0, snz_n = 0, h;

  csm_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(sin), .low_power_stop(low_power_stop),
    .serial_clock_pin(sclk), .serial_out_pin(sout), .channel_irq(irq),
    .snooze_rx_done(snz));
  csm_slave_model slave (.sclk(sclk), .sout(sout), .arm(arm), .lsb_first(lsb),
    .len8(len8), .data_phase(dap), .tx_word(tx_word), .sin(sin), .rx_word(rx_word));

  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (irq === 1'b1) irq_n++;
    if (snz === 1'b1) snz_n++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic idle();
    do begin
      apb(1'b0, CSM_OFS_STATUS, 32'h0);
    end while (rd[1:0] !== 2'b00);
  endtask
  // Software sets idle levels high for non-reversed clock
  task automatic cfg(input logic [31:0] md, cm, input logic l, n8, input logic [7:0] tw);
    idle();
    wr(CSM_OFS_STOP, 32'h1);
    wr(CSM_OFS_MODE, md);
    wr(CSM_OFS_COMM, cm);
    wr(CSM_OFS_OUT_LVL, 32'h101);
    wr(CSM_OFS_OUT_EN, {31'h0, cm[4]});
    lsb <= l;
    len8 <= n8;
    tx_word <= tw;
    dap <= cm[0];
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask
  task automatic half(output int n);
    logic s;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      s = sclk;
      for (int i = 0; i < 300 && sclk === s; i++) @(posedge pclk);
    end
    s = sclk;
    while (sclk === s && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(CSM_OFS_COMM, 32'h38, "comm reset");
    rdc(CSM_OFS_STATUS, 32'h0, "status reset");
    rdc(CSM_OFS_OUT_LVL, 32'h101, "level reset");
    rdc(CSM_OFS_OUT_EN, 32'h0, "out_en reset");
    rdc(12'h028, 32'h0, "unmapped data");
    chk(err, 1'b1, "unmapped slverr");
    chk({sclk, sout}, 2'b11, "idle pins");
    $display("test reset done");
  endtask
  task automatic t_tx();
    int n0;
    cfg(32'h0, 32'h38, 1'b0, 1'b1, 8'h5a);
    wr(CSM_OFS_DATA, 32'h3c);
    wr(CSM_OFS_DATA, 32'ha5);
    n0 = irq_n;
    wr(CSM_OFS_START, 32'h1);
    rdc(CSM_OFS_STATUS, 32'h0a, "enabled busy");
    idle();
    chk(rx_word, 8'ha5, "tx msb word replaced");
    apb(1'b0, CSM_OFS_DATA, 32'h0);
    chk(rd[7:0], 8'h5a, "rx msb word");
    chk(irq_n, n0 + 1, "end irq");
    $display("test tx done");
  endtask
  task automatic t_lsb7();
    cfg(32'h0, 32'h34, 1'b1, 1'b0, 8'h13);
    low_power_stop <= 1'b1;
    wr(CSM_OFS_START, 32'h1);
    wr(CSM_OFS_DATA, 32'h2b);
    idle();
    chk(rx_word, 8'h2b, "tx lsb 7-bit");
    apb(1'b0, CSM_OFS_DATA, 32'h0);
    chk(rd[6:0], 7'h13, "rx lsb 7-bit");
    chk(snz_n, 1, "stop-state rx");
    low_power_stop <= 1'b0;
    $display("test lsb7 done");
  endtask
  task automatic t_ovr();
    cfg(32'h0, 32'h28, 1'b0, 1'b1, 8'h77);
    wr(CSM_OFS_START, 32'h1);
    wr(CSM_OFS_DATA, 32'h201);
    wr(CSM_OFS_DATA, 32'h202);
    idle();
    chk(rd[2], 1'b1, "overrun set");
    chk(rx_word, 8'hff, "no data out in reception");
    wr(CSM_OFS_FLAG_CLR, 32'h1);
    rdc(CSM_OFS_STATUS, 32'h08, "overrun cleared");
    $display("test overrun done");
  endtask
  task automatic t_src();
    int n0;
    cfg(32'h1, 32'h38, 1'b0, 1'b1, 8'h00);
    wr(CSM_OFS_START, 32'h1);
    n0 = irq_n;
    wr(CSM_OFS_DATA, 32'h2c3);
    apb(1'b0, CSM_OFS_STATUS, 32'h0);
    chk(irq_n, n0 + 1, "empty irq");
    chk(rd[1], 1'b1, "loaded word active");
    wr(CSM_OFS_MODE, 32'h0);
    idle();
    chk(irq_n, n0 + 2, "live source change");
    $display("test source done");
  endtask
  task automatic t_rate();
    cfg(32'h0, 32'h38, 1'b0, 1'b1, 8'h00);
    wr(CSM_OFS_PRESCALE, 32'h21);
    wr(CSM_OFS_START, 32'h1);
    wr(CSM_OFS_DATA, 32'h200);
    half(h);
    chk(h, 4, "half period A");
    idle();
    wr(CSM_OFS_MODE, 32'h2);
    wr(CSM_OFS_DATA, 32'h200);
    half(h);
    chk(h, 8, "half period B");
    idle();
    wr(CSM_OFS_PRESCALE, 32'h0);
    $display("test rate done");
  endtask
  task automatic t_dap();
    cfg(32'h0, 32'h39, 1'b0, 1'b1, 8'hc5);
    wr(CSM_OFS_START, 32'h1);
    wr(CSM_OFS_DATA, 32'h2a3);
    for (int i = 0; i < 300; i++) begin
      @(posedge pclk);
      if (sclk === 1'b0) break;
      prev = sout;
    end
    chk(prev, 1'b1, "data before clock");
    idle();
    chk(rx_word, 8'ha3, "dap word");
    apb(1'b0, CSM_OFS_DATA, 32'h0);
    chk(rd[7:0], 8'hc5, "dap rx word");
    $display("test dap done");
  endtask
  task automatic t_stop();
    int n0;
    cfg(32'h0, 32'h38, 1'b0, 1'b1, 8'h00);
    wr(CSM_OFS_START, 32'h1);
    n0 = irq_n;
    wr(CSM_OFS_DATA, 32'hfe55);
    repeat (20) @(posedge pclk);
    wr(CSM_OFS_STOP, 32'h1);
    rdc(CSM_OFS_STATUS, 32'h0, "stopped");
    rdc(CSM_OFS_STOP, 32'h0, "stop reads zero");
    repeat (300) @(posedge pclk);
    chk(irq_n, n0, "no irq on abort");
    wr(CSM_OFS_OUT_EN, 32'h0);
    wr(CSM_OFS_OUT_LVL, 32'h0);
    // Pins follow the level register one edge later
    repeat (2) @(posedge pclk);
    chk({sclk, sout}, 2'b00, "manual levels");
    $display("test stop done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_lsb7();
    t_ovr();
    t_src();
    t_rate();
    t_dap();
    t_stop();
    tally_and_finish();
  end
  // Whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
